// >>> ectc_defs.svh
// Constants for the external cache termination controller.
`ifndef ECTC_DEFS_SVH
`define ECTC_DEFS_SVH
`define ECTC_ADDR_W        32
`define ECTC_IDX_W         6
`define ECTC_WAIT_STATES   0
`define ECTC_WRITE_THROUGH 1'b1
`define ECTC_INSTR_ONLY    1'b0
`define ECTC_FC_CPU        3'h7
`define ECTC_FC_UPROG      3'h2
`define ECTC_FC_SPROG      3'h6
`define ECTC_PIN_AS        0
`define ECTC_PIN_MACK      1
`define ECTC_PIN_BUS_ERROR_N      2
`define ECTC_PIN_HALT      3
`define ECTC_PIN_CNT       4
`endif

// >>> ectc_pkg.sv
// Types shared by the external cache termination controller.
package ectc_pkg;
  typedef enum logic [2:0] {
    IDLE,
    LOOKUP,
    DECIDE,
    SYS_WAIT,
    CLOSE
  } ectc_state_type;
endpackage

// >>> ectc_tag_if.sv
// Lookup, fill and flush signals between controller and tag store.
interface ectc_tag_if;
  logic        lookupReq;
  logic [31:0] lookupAddr;
  logic        hit;
  logic        hitValid;
  logic        fillReq;
  logic [31:0] fillAddr;
  logic        flushReq;
  logic        flushBusy;
  modport ctrl  (output lookupReq, lookupAddr, fillReq, fillAddr, flushReq,
                 input  hit, hitValid, flushBusy);
  modport store (input  lookupReq, lookupAddr, fillReq, fillAddr, flushReq,
                 output hit, hitValid, flushBusy);
endinterface

// >>> ectc_tag_store.sv
// Direct-mapped tag store with registered compare and walking flush.
`include "ectc_defs.svh"
module ectc_tag_store #(
  parameter int IDX_W = `ECTC_IDX_W
) (
  input wire logic clk,
  input wire logic rst_n,
  ectc_tag_if.store tif
);
  localparam int TAG_W   = 32 - IDX_W - 2;
  localparam int ENTRIES = 1 << IDX_W;

  logic [TAG_W-1:0] tagMem [ENTRIES];
  logic [ENTRIES-1:0] valid_reg,    valid_next;
  logic               hit_reg,      hit_next;
  logic               hitValid_reg, hitValid_next;
  logic               flushing_reg, flushing_next;
  logic [IDX_W-1:0]   flushIdx_reg, flushIdx_next;
  logic               wrEn;
  logic [IDX_W-1:0]   wrIdx;

  function automatic logic [IDX_W-1:0] idxOf(input logic [31:0] a);
    return a[IDX_W+1:2];
  endfunction

  function automatic logic [TAG_W-1:0] tagOf(input logic [31:0] a);
    return a[31:IDX_W+2];
  endfunction

  always_comb begin
    valid_next    = valid_reg;
    flushing_next = flushing_reg;
    flushIdx_next = flushIdx_reg;
    wrEn          = 1'b0;
    wrIdx         = idxOf(tif.fillAddr);
    // The compare result is registered so the hit only appears once settled.
    hitValid_next = tif.lookupReq;
    hit_next      = tif.lookupReq && !flushing_reg &&
                    valid_reg[idxOf(tif.lookupAddr)] &&
                    tagMem[idxOf(tif.lookupAddr)] == tagOf(tif.lookupAddr);
    if (flushing_reg) begin
      // One entry per clock keeps the clear logic small; fills are ignored meanwhile.
      valid_next[flushIdx_reg] = 1'b0;
      flushIdx_next = flushIdx_reg + 1'b1;
      if (&flushIdx_reg) begin
        flushing_next = 1'b0;
      end
    end else if (tif.flushReq) begin
      flushing_next = 1'b1;
      flushIdx_next = '0;
    end else if (tif.fillReq) begin
      wrEn = 1'b1;
      valid_next[wrIdx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg    <= '0;
      hit_reg      <= 1'b0;
      hitValid_reg <= 1'b0;
      flushing_reg <= 1'b1;
      flushIdx_reg <= '0;
    end else begin
      valid_reg    <= valid_next;
      hit_reg      <= hit_next;
      hitValid_reg <= hitValid_next;
      flushing_reg <= flushing_next;
      flushIdx_reg <= flushIdx_next;
    end
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      tagMem[wrIdx] <= tagOf(tif.fillAddr);
    end
  end

  assign tif.hit       = hit_reg;
  assign tif.hitValid  = hitValid_reg;
  assign tif.flushBusy = flushing_reg;

  chk_lookup_settle: assert property (
    @(posedge clk) disable iff (!rst_n)
    tif.lookupReq |=> tif.hitValid ##1 !tif.hitValid)
    else $error("Lookup result not presented exactly one clock later.");

  chk_flush_clears_all: assert property (
    @(posedge clk) disable iff (!rst_n)
    (flushing_reg && &flushIdx_reg) |=> valid_reg == '0)
    else $error("Entries left valid after a full clear.");
endmodule

// >>> ectc_cache_ctrl.sv
// Cache controller that ends processor cycles and retries early-terminated cache misses.
// Function
// - On a hit assert termination and keep address strobe from the system.
// - Forward the address strobe only once the hit/miss decision is valid.
// - Provide clearing of all entries and creation of new entries.
// - Hold the hit until compare settles, then drive termination directly.
// - In early mode assert termination the clock after the synchronized strobe starts the cycle, ahead of the decision.
// - No early termination for CPU space, write-through writes, inhibited.
// - No early termination after an unretried cachable miss last cycle.
// - Capture the termination condition when address strobe negates.
// - Early termination output settles before bus state one begins.
// - Cachable early cycle without hit drives bus error and halt low.
// - Wait states delay early termination by extra clocked stages.
// - Hold the system address strobe of a missed cycle through retry.
// - Instruction-only mode caches program fetches only, by function code.
// - Bus error alone aborts; bus error with halt retries the cycle.
`include "ectc_defs.svh"
module ectc_cache_ctrl #(
  parameter int   WAIT_STATES   = `ECTC_WAIT_STATES,
  parameter logic WRITE_THROUGH = `ECTC_WRITE_THROUGH,
  parameter logic INSTR_ONLY    = `ECTC_INSTR_ONLY
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] cpuAddr,
  input  wire logic [2:0]  cpuFuncCode,
  input  wire logic        cpuRead,
  input  wire logic        addr_strobe_n,
  input  wire logic        cache_inhibit_out_n,
  input  wire logic        earlyTermEn,
  input  wire logic        flushReq,
  input  wire logic        memAck_n,
  input  wire logic        busErrorInN,
  input  wire logic        haltInN,
  output logic             sync_cycle_term_n,
  output logic             sysAddrStrobe_n,
  output logic             bus_error_n_out,
  output logic             bus_error_n_oe,
  output logic             halt_n_out,
  output logic             halt_n_oe,
  output logic             flushBusy
);
  localparam int EarlyLat = WAIT_STATES;
  localparam int PinCnt   = `ECTC_PIN_CNT;

  ectc_tag_if tif ();

  ectc_tag_store u_tags (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif.store)
  );

  ectc_pkg::ectc_state_type state_reg, state_next;
  logic [PinCnt-1:0][2:0] pinSh_reg,   pinSh_next;
  logic [PinCnt-1:0]      pinLvl_reg,  pinLvl_next;
  logic [PinCnt-1:0]      pinRaw;
  logic        asPrev_reg,      asPrev_next;
  logic [31:0] addr_reg,        addr_next;
  logic [2:0]  fc_reg,          fc_next;
  logic        read_reg,        read_next;
  logic        cachable_reg,    cachable_next;
  logic        early_reg,       early_next;
  logic        miss_reg,        miss_next;
  logic        retried_reg,     retried_next;
  logic        prevMiss_reg,    prevMiss_next;
  logic [3:0]  termCnt_reg,     termCnt_next;
  logic        term_reg,        term_next;
  logic        sysAs_reg,       sysAs_next;
  logic        errOe_reg,       errOe_next;
  logic        busy_reg,        busy_next;
  logic        hitSeen_reg,     hitSeen_next;
  logic        asAct;
  logic        memAckAct;
  logic        cachableNow;
  logic        earlyNow;
  logic        hitNow;

  function automatic logic isProgram(input logic [2:0] fc);
    return fc == `ECTC_FC_UPROG || fc == `ECTC_FC_SPROG;
  endfunction

  assign pinRaw    = {haltInN, busErrorInN, memAck_n, addr_strobe_n};
  assign asAct     = !pinLvl_reg[`ECTC_PIN_AS];
  assign memAckAct = !pinLvl_reg[`ECTC_PIN_MACK];
  assign hitNow    = hitSeen_reg;

  // Cachability of the cycle being started, judged from the pins.
  always_comb begin
    cachableNow = cache_inhibit_out_n && cpuFuncCode != `ECTC_FC_CPU &&
                  (!INSTR_ONLY || isProgram(cpuFuncCode));
    earlyNow    = earlyTermEn && cachableNow &&
                  !(!cpuRead && WRITE_THROUGH) &&
                  !prevMiss_reg;
  end

  always_comb begin
    for (int i = 0; i < PinCnt; i++) begin
      pinSh_next[i]  = {pinSh_reg[i][1:0], pinRaw[i]};
      pinLvl_next[i] = (pinSh_reg[i][1] == pinSh_reg[i][2]) ?
                       pinSh_reg[i][1] : pinLvl_reg[i];
    end
  end

  always_comb begin
    state_next     = state_reg;
    asPrev_next    = asAct;
    addr_next      = addr_reg;
    fc_next        = fc_reg;
    read_next      = read_reg;
    cachable_next  = cachable_reg;
    early_next     = early_reg;
    miss_next      = miss_reg;
    retried_next   = retried_reg;
    prevMiss_next  = prevMiss_reg;
    termCnt_next   = termCnt_reg;
    term_next      = term_reg;
    sysAs_next     = sysAs_reg;
    errOe_next     = errOe_reg;
    busy_next      = tif.flushBusy;
    // The store shows its compare for one clock only, so DECIDE keeps it.
    hitSeen_next   = tif.hitValid ? (tif.hit && cachable_reg) :
                     hitSeen_reg;
    tif.lookupReq  = 1'b0;
    tif.lookupAddr = addr_reg;
    tif.fillReq    = 1'b0;
    tif.fillAddr   = addr_reg;
    tif.flushReq   = flushReq;
    // The condition of the ending cycle is kept for the next one.
    if (asPrev_reg && !asAct) begin
      prevMiss_next = miss_reg && !retried_reg && cachable_reg;
    end
    // Early termination waits out the configured wait states first.
    if (early_reg && state_reg != ectc_pkg::IDLE &&
        state_reg != ectc_pkg::CLOSE) begin
      if (termCnt_reg != 4'h0) begin
        termCnt_next = termCnt_reg - 4'h1;
      end else begin
        term_next = 1'b1;
      end
    end
    unique case (state_reg)
      ectc_pkg::IDLE: begin
        if (asAct && !tif.flushBusy && pinLvl_reg[`ECTC_PIN_BUS_ERROR_N] &&
            pinLvl_reg[`ECTC_PIN_HALT]) begin
          addr_next      = cpuAddr;
          fc_next        = cpuFuncCode;
          read_next      = cpuRead;
          cachable_next  = cachableNow;
          early_next     = earlyNow;
          miss_next      = 1'b0;
          retried_next   = 1'b0;
          termCnt_next   = 4'(EarlyLat);
          tif.lookupReq  = 1'b1;
          tif.lookupAddr = cpuAddr;
          state_next     = ectc_pkg::LOOKUP;
        end
      end
      ectc_pkg::LOOKUP: begin
        state_next = ectc_pkg::DECIDE;
      end
      ectc_pkg::DECIDE: begin
        if (hitNow) begin
          term_next  = 1'b1;
          state_next = ectc_pkg::CLOSE;
        end else begin
          miss_next  = 1'b1;
          sysAs_next = 1'b1;
          if (early_reg) begin
            errOe_next   = 1'b1;
            retried_next = 1'b1;
          end
          state_next = ectc_pkg::SYS_WAIT;
        end
      end
      ectc_pkg::SYS_WAIT: begin
        // Memory keeps running while the processor waits to retry.
        if (memAckAct) begin
          sysAs_next = 1'b0;
          term_next  = !early_reg;
          errOe_next = 1'b0;
          // The retry reuses the driven address, so the fill matches it.
          tif.fillReq = cachable_reg && read_reg;
          state_next  = ectc_pkg::CLOSE;
        end
      end
      ectc_pkg::CLOSE: begin
        if (!asAct) begin
          term_next  = 1'b0;
          errOe_next = 1'b0;
          early_next = 1'b0;
          state_next = ectc_pkg::IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ectc_pkg::IDLE;
      pinSh_reg    <= '1;
      pinLvl_reg   <= '1;
      asPrev_reg   <= 1'b0;
      addr_reg     <= 32'h0000_0000;
      fc_reg       <= 3'h0;
      read_reg     <= 1'b1;
      cachable_reg <= 1'b0;
      early_reg    <= 1'b0;
      miss_reg     <= 1'b0;
      retried_reg  <= 1'b0;
      prevMiss_reg <= 1'b0;
      termCnt_reg  <= 4'h0;
      term_reg     <= 1'b0;
      sysAs_reg    <= 1'b0;
      errOe_reg    <= 1'b0;
      busy_reg     <= 1'b1;
      hitSeen_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pinSh_reg    <= pinSh_next;
      pinLvl_reg   <= pinLvl_next;
      asPrev_reg   <= asPrev_next;
      addr_reg     <= addr_next;
      fc_reg       <= fc_next;
      read_reg     <= read_next;
      cachable_reg <= cachable_next;
      early_reg    <= early_next;
      miss_reg     <= miss_next;
      retried_reg  <= retried_next;
      prevMiss_reg <= prevMiss_next;
      termCnt_reg  <= termCnt_next;
      term_reg     <= term_next;
      sysAs_reg    <= sysAs_next;
      errOe_reg    <= errOe_next;
      busy_reg     <= busy_next;
      hitSeen_reg  <= hitSeen_next;
    end
  end

  // Open-drain lines only ever pull low, so the data side is constant.
  assign sync_cycle_term_n = !term_reg;
  assign sysAddrStrobe_n   = !sysAs_reg;
  assign bus_error_n_out   = 1'b0;
  assign halt_n_out        = 1'b0;
  assign bus_error_n_oe    = errOe_reg;
  assign halt_n_oe         = errOe_reg;
  assign flushBusy         = busy_reg;

  chk_hit_blocks_strobe: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == ectc_pkg::DECIDE && hitNow) |=>
      (term_reg && !sysAs_reg) [*2])
    else $error("Hit did not terminate or let the strobe out.");

  chk_strobe_after_decide: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(sysAs_reg) |-> $past(state_reg) == ectc_pkg::DECIDE && !$past(hitNow))
    else $error("System strobe forwarded before a miss decision.");

  chk_late_term_source: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(term_reg) && !early_reg) |->
      $past(state_reg) inside {ectc_pkg::DECIDE, ectc_pkg::SYS_WAIT})
    else $error("Validated termination came before the decision.");

  chk_early_latency: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(early_reg) |-> ##[EarlyLat:EarlyLat] !term_reg ##1 term_reg)
    else $error("Early termination latency is wrong.");

  chk_early_suppress: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(early_reg) |-> fc_reg != `ECTC_FC_CPU && cachable_reg &&
      !(!read_reg && WRITE_THROUGH))
    else $error("Early termination on a suppressed cycle.");

  chk_prev_miss: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(early_reg) |-> !$past(prevMiss_reg))
    else $error("Early termination after an unretried miss.");

  chk_retry_pair: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(errOe_reg) |-> early_reg && miss_reg && cachable_reg &&
      $past(state_reg) == ectc_pkg::DECIDE)
    else $error("Bus error and halt driven without an early miss.");

  chk_retry_holds_strobe: assert property (
    @(posedge clk) disable iff (!rst_n)
    errOe_reg |-> sysAs_reg)
    else $error("System strobe dropped while the retry is pending.");

  chk_no_fill_inhibit: assert property (
    @(posedge clk) disable iff (!rst_n)
    tif.fillReq |-> cachable_reg && fc_reg != `ECTC_FC_CPU)
    else $error("Entry allocated for an inhibited or CPU space cycle.");

  cov_hit: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ectc_pkg::DECIDE && hitNow);
  cov_early_retry: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(errOe_reg));
  cov_plain_miss: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(sysAs_reg) && !early_reg);
  cov_fill: cover property (@(posedge clk) disable iff (!rst_n)
    tif.fillReq);
endmodule

// >>> ectc_cpu_model.sv
// Processor and main memory model facing the cache controller.
module ectc_cpu_model (
  input  wire logic        clk,
  input  wire logic        sync_cycle_term_n,
  input  wire logic        sysAddrStrobe_n,
  input  wire logic        bus_error_n_oe,
  input  wire logic        halt_n_oe,
  output logic [31:0]      cpuAddr,
  output logic [2:0]       cpuFuncCode,
  output logic             cpuRead,
  output logic             addr_strobe_n,
  output logic             cache_inhibit_out_n,
  output logic             memAck_n,
  output logic             busErrorInN,
  output logic             haltInN
);
  timeunit 1ns;
  timeprecision 1ns;
  int   memDelay = 4;
  int   memCnt = 0;
  logic sysSeen = 1'b0;
  // Both lines have pull-ups, so they read low only while pulled.
  assign busErrorInN = ~bus_error_n_oe;
  assign haltInN     = ~halt_n_oe;
  initial begin
    cpuAddr = 32'h0;
    cpuFuncCode = 3'h1;
    cpuRead = 1'b1;
    addr_strobe_n = 1'b1;
    cache_inhibit_out_n = 1'b1;
    memAck_n = 1'b1;
  end
  // The ack is kept until the system strobe is released.
  always @(negedge clk) begin
    if (sysAddrStrobe_n) begin
      memCnt <= 0;
      memAck_n <= 1'b1;
    end else begin
      sysSeen <= 1'b1;
      if (memCnt >= memDelay) memAck_n <= 1'b0;
      else memCnt <= memCnt + 1;
    end
  end
  task automatic cycle(input logic [31:0] a, input logic [2:0] fc,
                       input logic rd, input logic inh, output int termAt,
                       output int sysAt, output logic retried,
                       output logic held, output logic miss);
    int n;
    sysAt = -1;
    n = 0;
    @(negedge clk);
    sysSeen = 1'b0;
    cpuAddr = a;
    cpuFuncCode = fc;
    cpuRead = rd;
    cache_inhibit_out_n = ~inh;
    addr_strobe_n = 1'b0;
    while (sync_cycle_term_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
      if (sysAt < 0 && sysAddrStrobe_n === 1'b0) sysAt = n;
    end
    termAt = n;
    // A late retry shows about one clock after termination.
    @(negedge clk);
    retried = (busErrorInN === 1'b0) && (haltInN === 1'b0);
    held = (sysAddrStrobe_n === 1'b0);
    addr_strobe_n = 1'b1;
    n = 0;
    // The address stays driven while halt holds the retry off.
    while ((sync_cycle_term_n !== 1'b1 || haltInN !== 1'b1) && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    miss = sysSeen;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the external cache termination controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        earlyTermEn = 1'b0;
  logic        flushReq = 1'b0;
  logic [31:0] cpuAddr;
  logic [2:0]  cpuFuncCode;
  logic        cpuRead, asN, inhN, memAck_n, berrN, haltN;
  logic        termN, sysN, berrOut, berrOe, haltOut, haltOe, flushBusy;
  int          errTotal = 0;
  int          checked = 0;
  int          cyc = 0;
  // Four clocks of strobe sync, then take, lookup and decide.
  localparam int HitLat = 7;
  int          t, s;
  logic        r, h, m;

  always #50 clk = ~clk;

  ectc_cache_ctrl dut (.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr),
    .cpuFuncCode(cpuFuncCode), .cpuRead(cpuRead), .addr_strobe_n(asN),
    .cache_inhibit_out_n(inhN), .earlyTermEn(earlyTermEn),
    .flushReq(flushReq), .memAck_n(memAck_n), .busErrorInN(berrN),
    .haltInN(haltN), .sync_cycle_term_n(termN), .sysAddrStrobe_n(sysN),
    .bus_error_n_out(berrOut), .bus_error_n_oe(berrOe),
    .halt_n_out(haltOut), .halt_n_oe(haltOe), .flushBusy(flushBusy));

  ectc_cpu_model cpu (.clk(clk), .sync_cycle_term_n(termN),
    .sysAddrStrobe_n(sysN), .bus_error_n_oe(berrOe), .halt_n_oe(haltOe),
    .cpuAddr(cpuAddr), .cpuFuncCode(cpuFuncCode), .cpuRead(cpuRead),
    .addr_strobe_n(asN), .cache_inhibit_out_n(inhN), .memAck_n(memAck_n),
    .busErrorInN(berrN), .haltInN(haltN));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: %s saw %0h wanted %0h", $time, what,
               seen, exp);
    end
  endtask

  task automatic run(input logic [31:0] a, input logic [2:0] fc,
                     input logic rd, input logic inh);
    cpu.cycle(a, fc, rd, inh, t, s, r, h, m);
  endtask

  task automatic waitIdle();
    for (int i = 0; i < 300 && flushBusy !== 1'b0; i++) @(negedge clk);
    check(flushBusy, 1'b0, "flush end");
  endtask

  task automatic testHitPlain();
    run(32'h0000_1004, 3'h1, 1'b1, 1'b0);
    check(m, 1'b1, "first read misses");
    check(s, HitLat, "miss strobe time");
    run(32'h0000_1004, 3'h1, 1'b1, 1'b0);
    check(m, 1'b0, "hit keeps system strobe");
    check(t, HitLat, "hit time vs decision");
    $display("test hit_plain done");
  endtask

  task automatic testEarly();
    @(negedge clk);
    earlyTermEn = 1'b1;
    run(32'h0002_2008, 3'h1, 1'b1, 1'b0);
    check(t, HitLat - 1, "early term time");
    check(r, 1'b1, "miss retried");
    check(h, 1'b1, "system strobe held");
    check(berrOut | haltOut, 1'b0, "pulled lines drive low");
    run(32'h0002_2008, 3'h1, 1'b1, 1'b0);
    check(m, 1'b0, "retry hits");
    check(r, 1'b0, "retry not refused");
    check(t, HitLat - 1, "early hit time");
    $display("test early done");
  endtask

  task automatic testSuppress();
    logic [2:0] fcs [3] = '{3'h7, 3'h1, 3'h1};
    logic       rds [3] = '{1'b1, 1'b0, 1'b1};
    logic       ihs [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      run(32'h0030_0010 + 32'(i * 4), fcs[i], rds[i], ihs[i]);
      check(r, 1'b0, "suppressed no retry");
      check(m, 1'b1, "suppressed to memory");
    end
    run(32'h0040_0040, 3'h5, 1'b1, 1'b0);
    check(r, 1'b1, "after noncachable");
    run(32'h0040_0040, 3'h5, 1'b1, 1'b0);
    check(r, 1'b0, "noncachable retry hits");
    @(negedge clk);
    earlyTermEn = 1'b0;
    run(32'h0030_0010, 3'h1, 1'b1, 1'b0);
    check(m, 1'b1, "cpu space not filled");
    run(32'h0030_0018, 3'h1, 1'b1, 1'b0);
    check(m, 1'b1, "inhibited not filled");
    $display("test suppress done");
  endtask

  task automatic testPrevMiss();
    run(32'h0050_0080, 3'h1, 1'b0, 1'b0);
    @(negedge clk);
    earlyTermEn = 1'b1;
    run(32'h0060_0084, 3'h1, 1'b1, 1'b0);
    check(r, 1'b0, "after unretried miss");
    check(m, 1'b1, "went to memory");
    run(32'h0060_0084, 3'h1, 1'b1, 1'b0);
    check(t, HitLat, "still suppressed");
    run(32'h0060_0084, 3'h1, 1'b1, 1'b0);
    check(t, HitLat - 1, "early again");
    @(negedge clk);
    earlyTermEn = 1'b0;
    $display("test prev_miss done");
  endtask

  task automatic testFlush();
    @(negedge clk);
    flushReq = 1'b1;
    @(negedge clk);
    flushReq = 1'b0;
    repeat (2) @(negedge clk);
    check(flushBusy, 1'b1, "flush started");
    waitIdle();
    run(32'h0000_1004, 3'h1, 1'b1, 1'b0);
    check(m, 1'b1, "entry cleared");
    $display("test flush done");
  endtask

  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The run needs well under 2000 clocks; the ceiling leaves ample room.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errTotal++;
      $display("unexpected at %0t: run did not finish", $time);
      closeOut();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    waitIdle();
    testHitPlain();
    testEarly();
    testSuppress();
    testPrevMiss();
    testFlush();
    closeOut();
  end
endmodule
